// ### core/iag_pkg.sv
/*
 * Constants and types for the indexed operand address generator.
 * Assumes a single 20 MHz core clock and an instruction sequencer that
 * presents one operand request per cycle.
 */
// Overview of operation
// - Three 16-bit signed index registers kept.
// - All index registers behave identically in single loads and indexing.
// - Direct addressing passes operand address unchanged.
// - Indexed address is base plus signed index.
// - Indexing allowed only for RW, T, C, D.
// - Index registers loaded as ordinary instruction destinations.
// - Double-length pairs only second-first, third-second.
// - No range check on effective address.
// - Loads and indexed accesses repeat without limit.
package iag_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int unsigned IDX_W = 16;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned NUM_IDX = 3;

	// ----------------------------------------
	// Reset values and register space codes
	// ----------------------------------------
	localparam logic [15:0] IDX_RST = 16'h0000;
	localparam logic [15:0] IDX_MIN = 16'h8000;
	localparam logic [15:0] IDX_MAX = 16'h7fff;

	typedef enum logic [2:0] {
		IAG_SPC_RW,
		IAG_SPC_T,
		IAG_SPC_C,
		IAG_SPC_D,
		IAG_SPC_X,
		IAG_SPC_Y,
		IAG_SPC_S,
		IAG_SPC_OTHER
	} iag_space_t;

	typedef enum logic [1:0] {
		IAG_SEL_NONE,
		IAG_SEL_FIRST,
		IAG_SEL_SECOND,
		IAG_SEL_THIRD
	} iag_sel_t;
endpackage

// ### core/iag_idx_regs.sv
/*
 * Index register bank: three 16-bit words with one write port
 * and two registered read ports for the source and destination operands.
 * Assumes the caller has already validated the write request.
 */
module iag_idx_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_sync_n,
	// Write port
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [15:0] wr_data,
	// Read ports
	input wire logic [1:0] rd_a_sel,
	input wire logic [1:0] rd_b_sel,
	output logic [15:0] rd_a_data,
	output logic [15:0] rd_b_data,
	// Whole bank for pair reads
	output logic [47:0] bank
);
	logic [15:0] mem_ff [3];
	logic [15:0] rd_a_ff;
	logic [15:0] rd_b_ff;

	// One entry per register; selection 0 means no index register
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mem_ff[0] <= iag_pkg::IDX_RST;
			mem_ff[1] <= iag_pkg::IDX_RST;
			mem_ff[2] <= iag_pkg::IDX_RST;
		end else if (wr_en && wr_sel != 2'h0) begin
			mem_ff[wr_sel - 2'h1] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_a_ff <= iag_pkg::IDX_RST;
			rd_b_ff <= iag_pkg::IDX_RST;
		end else begin
			rd_a_ff <= (rd_a_sel == 2'h0) ? 16'h0000 : mem_ff[rd_a_sel - 2'h1];
			rd_b_ff <= (rd_b_sel == 2'h0) ? 16'h0000 : mem_ff[rd_b_sel - 2'h1];
		end
	end

	assign rd_a_data = rd_a_ff;
	assign rd_b_data = rd_b_ff;
	assign bank = {mem_ff[2], mem_ff[1], mem_ff[0]};
endmodule

// ### core/iag_top.sv
/*
 * Indexed operand address generator: forms effective register addresses
 * for source and destination operands, and hosts the index register bank.
 * Assumes the sequencer holds a request for the cycle it presents it and
 * takes results one cycle later; index writes come from the result bus.
 */
module iag_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Operand request
	input wire logic req_valid,
	input wire logic [15:0] src_base,
	input wire logic [2:0] src_space,
	input wire logic [1:0] src_idx_sel,
	input wire logic [15:0] dst_base,
	input wire logic [2:0] dst_space,
	input wire logic [1:0] dst_idx_sel,
	// Effective addresses
	output logic ea_valid,
	output logic [15:0] src_ea,
	output logic [15:0] dst_ea,
	output logic idx_refused,
	// Index register load from instruction result
	input wire logic idx_wr_en,
	input wire logic [1:0] idx_wr_sel,
	input wire logic [15:0] idx_wr_data,
	// Double-length pair load and read
	input wire logic pair_wr_en,
	input wire logic [1:0] pair_low_sel,
	input wire logic [31:0] pair_wr_data,
	output logic pair_refused,
	output logic [31:0] pair_rd_data
);
	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_s1_ff;
	logic rst_sync_n_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_ff <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_sync_n_ff <= rst_s1_ff;
		end
	end

	// Everything below resets from this copy, so release never races the clock
	wire rst_sync_n = rst_sync_n_ff;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Only RW, T, C and D accept an index
	function automatic logic space_indexable(input logic [2:0] spc);
		space_indexable = (spc == iag_pkg::IAG_SPC_RW) || (spc == iag_pkg::IAG_SPC_T) ||
			(spc == iag_pkg::IAG_SPC_C) || (spc == iag_pkg::IAG_SPC_D);
	endfunction

	// Wraps to the address width; the program owns the range
	function automatic logic [15:0] add_index(input logic [15:0] base, input logic [15:0] idx);
		add_index = base + idx;
	endfunction

	// Low register must be first or second so its upper neighbour exists
	function automatic logic pair_ok(input logic [1:0] low_sel);
		pair_ok = (low_sel == iag_pkg::IAG_SEL_FIRST) || (low_sel == iag_pkg::IAG_SEL_SECOND);
	endfunction

	// ----------------------------------------
	// Index write arbitration
	// ----------------------------------------
	wire pair_go = pair_wr_en && pair_ok(pair_low_sel);
	wire pair_bad = pair_wr_en && !pair_ok(pair_low_sel);
	wire [1:0] pair_high_sel = pair_low_sel + 2'h1;
	// The low half of a pair takes the write port at once and drops a single write in that cycle; the high half is
	// written in a second cycle, dropping any single write or new pair there, to keep the bank at one write port.
	logic pair_hi_pend_ff;
	logic [1:0] pair_hi_sel_ff;
	logic [15:0] pair_hi_data_ff;

	wire wr_en = idx_wr_en || pair_go || pair_hi_pend_ff;
	wire [1:0] wr_sel = pair_hi_pend_ff ? pair_hi_sel_ff : (pair_go ? pair_low_sel : idx_wr_sel);
	wire [15:0] wr_data = pair_hi_pend_ff ? pair_hi_data_ff : (pair_go ? pair_wr_data[15:0] : idx_wr_data);

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pair_hi_pend_ff <= 1'b0;
			pair_hi_sel_ff <= 2'h0;
			pair_hi_data_ff <= 16'h0000;
		end else begin
			pair_hi_pend_ff <= pair_go && !pair_hi_pend_ff;
			pair_hi_sel_ff <= pair_high_sel;
			pair_hi_data_ff <= pair_wr_data[31:16];
		end
	end

	// ----------------------------------------
	// Index bank
	// ----------------------------------------
	logic [15:0] src_idx_val;
	logic [15:0] dst_idx_val;
	logic [47:0] bank;

	// Effective index selection drops an index on a non-indexable space
	wire src_idx_ok = space_indexable(src_space);
	wire dst_idx_ok = space_indexable(dst_space);
	wire [1:0] src_sel_eff = src_idx_ok ? src_idx_sel : 2'h0;
	wire [1:0] dst_sel_eff = dst_idx_ok ? dst_idx_sel : 2'h0;

	iag_idx_regs iag_idx_regs_inst (
		.clk(clk),
		.rst_sync_n(rst_sync_n),
		.wr_en(wr_en),
		.wr_sel(wr_sel),
		.wr_data(wr_data),
		.rd_a_sel(src_sel_eff),
		.rd_b_sel(dst_sel_eff),
		.rd_a_data(src_idx_val),
		.rd_b_data(dst_idx_val),
		.bank(bank)
	);

	// ----------------------------------------
	// Address stage
	// ----------------------------------------
	// Bank read is registered, so bases travel one cycle alongside it
	logic valid_ff;
	logic [15:0] src_base_ff;
	logic [15:0] dst_base_ff;
	logic refused_ff;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			valid_ff <= 1'b0;
			src_base_ff <= 16'h0000;
			dst_base_ff <= 16'h0000;
			refused_ff <= 1'b0;
		end else begin
			valid_ff <= req_valid;
			src_base_ff <= src_base;
			dst_base_ff <= dst_base;
			refused_ff <= req_valid && ((!src_idx_ok && src_idx_sel != 2'h0) ||
				(!dst_idx_ok && dst_idx_sel != 2'h0));
		end
	end

	// Zero index gives the base unchanged, i.e. direct addressing
	assign ea_valid = valid_ff;
	assign src_ea = add_index(src_base_ff, src_idx_val);
	assign dst_ea = add_index(dst_base_ff, dst_idx_val);
	assign idx_refused = refused_ff;
	assign pair_refused = pair_bad;

	// Pair read follows the low selection; illegal pairs read zero
	wire [1:0] pr_sel = pair_low_sel;
	assign pair_rd_data = (pr_sel == iag_pkg::IAG_SEL_FIRST) ? bank[31:0] :
		(pr_sel == iag_pkg::IAG_SEL_SECOND) ? bank[47:16] : 32'h0000_0000;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_direct_unchanged: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && src_idx_sel == 2'h0 && !pair_hi_pend_ff && !idx_wr_en && !pair_wr_en)
		|=> src_ea == $past(src_base)) else $error("direct source address altered");

	a_indexed_sum: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && src_idx_sel == 2'h1 && src_idx_ok)
		|=> src_ea == 16'($past(src_base) + $past(bank[15:0]))) else $error("indexed sum wrong");

	a_space_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && !dst_idx_ok) |=> dst_ea == $past(dst_base)) else $error("index applied to bad space");

	a_refuse_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && !src_idx_ok && src_idx_sel != 2'h0)
		|=> idx_refused) else $error("index on closed space not flagged");

	a_dst_indexed: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && dst_idx_sel == 2'h3 && dst_idx_ok)
		|=> dst_ea == 16'($past(dst_base) + $past(bank[47:32]))) else $error("destination sum wrong");

	a_dst_direct: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && dst_idx_sel == 2'h0)
		|=> dst_ea == $past(dst_base)) else $error("direct destination address altered");

	a_ea_follows: assert property (@(posedge clk) disable iff (!rst_sync_n)
		req_valid
		|=> ea_valid) else $error("request left unanswered");

	a_load_visible: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(idx_wr_en && idx_wr_sel == 2'h2 && !pair_wr_en && !pair_hi_pend_ff)
		|=> bank[31:16] == $past(idx_wr_data)) else $error("index load lost");

	a_pair_legal: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(pair_wr_en && pair_low_sel == 2'h3) |-> pair_refused && !pair_go) else $error("illegal pair accepted");

	a_pair_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(pair_go && !pair_hi_pend_ff && pair_low_sel == 2'h1 && !idx_wr_en) ##1 !pair_wr_en
		|=> bank[31:0] == $past(pair_wr_data, 2)) else $error("pair write wrong");

	a_no_range_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(req_valid && src_idx_ok && dst_idx_ok) |=> !idx_refused) else $error("flag raised on wrap");

	a_wr_changes: assert property (@(posedge clk) disable iff (!rst_sync_n)
		$changed(bank) |-> $past(wr_en)) else $error("bank changed without load");

	a_wrap_silent: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(ea_valid && src_ea < src_base_ff && !src_idx_val[15]) |-> !idx_refused) else $error("wrap flagged");

	// ----------------------------------------
	// Double-length pair checks
	// ----------------------------------------
	a_pair_high: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(pair_go && !pair_hi_pend_ff && pair_low_sel == 2'h2 && !idx_wr_en) ##1 !pair_wr_en
		|=> bank[47:16] == $past(pair_wr_data, 2)) else $error("upper pair write wrong");

	a_pair_bad_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(pair_bad && !pair_hi_pend_ff && !idx_wr_en)
		|=> $stable(bank)) else $error("refused pair altered the bank");

	a_pair_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(pair_low_sel == 2'h0 || pair_low_sel == 2'h3)
		|-> pair_rd_data == 32'h0000_0000) else $error("illegal pair read not zero");
endmodule

// ### testbench/iag_top_tb.sv
/*
 * Self-checking bench for the indexed operand address generator.
 * Assumes a 50 ns clock and results one cycle after each request.
 */
module iag_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic [15:0] src_base = 16'h0000;
	logic [2:0] src_space = 3'h0;
	logic [1:0] src_idx_sel = 2'h0;
	logic [15:0] dst_base = 16'h0000;
	logic [2:0] dst_space = 3'h0;
	logic [1:0] dst_idx_sel = 2'h0;
	logic idx_wr_en = 1'b0;
	logic [1:0] idx_wr_sel = 2'h0;
	logic [15:0] idx_wr_data = 16'h0000;
	logic pair_wr_en = 1'b0;
	logic [1:0] pair_low_sel = 2'h0;
	logic [31:0] pair_wr_data = 32'h0000_0000;
	logic ea_valid, idx_refused, pair_refused;
	logic [15:0] src_ea, dst_ea;
	logic [31:0] pair_rd_data;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	always #25 clk = ~clk;

	iag_top iag_top_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .src_base(src_base),
		.src_space(src_space), .src_idx_sel(src_idx_sel), .dst_base(dst_base), .dst_space(dst_space),
		.dst_idx_sel(dst_idx_sel), .ea_valid(ea_valid), .src_ea(src_ea), .dst_ea(dst_ea),
		.idx_refused(idx_refused), .idx_wr_en(idx_wr_en), .idx_wr_sel(idx_wr_sel),
		.idx_wr_data(idx_wr_data), .pair_wr_en(pair_wr_en), .pair_low_sel(pair_low_sel),
		.pair_wr_data(pair_wr_data), .pair_refused(pair_refused), .pair_rd_data(pair_rd_data));

	task automatic tally_and_finish;
		$display("mismatches %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard: the whole run needs well under 300 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 2000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step;
		@(posedge clk);
		#2;
	endtask

	// The request strobe drops as this one rises, so no signal changes twice in a step
	task automatic load_idx(input logic [1:0] sel, input logic [15:0] val);
		req_valid = 1'b0;
		idx_wr_en = 1'b1;
		idx_wr_sel = sel;
		idx_wr_data = val;
		step();
		check({31'h0, ea_valid}, 32'h0000_0000);
	endtask

	task automatic op(input logic [2:0] sp, input logic [1:0] sel, input logic [15:0] sb, input logic [15:0] db,
		input logic [15:0] es, input logic [15:0] ed, input logic er);
		idx_wr_en = 1'b0;
		req_valid = 1'b1;
		src_space = sp;
		dst_space = sp;
		src_idx_sel = sel;
		dst_idx_sel = sel;
		src_base = sb;
		dst_base = db;
		step();
		check({31'h0, ea_valid}, 32'h0000_0001);
		check({src_ea, dst_ea}, {es, ed});
		check({31'h0, idx_refused}, {31'h0, er});
	endtask

	task automatic pair(input logic [1:0] sel, input logic [31:0] data, input logic er);
		req_valid = 1'b0;
		idx_wr_en = 1'b0;
		pair_wr_en = 1'b1;
		pair_low_sel = sel;
		pair_wr_data = data;
		#1;
		check({31'h0, pair_refused}, {31'h0, er});
		step();
		pair_wr_en = 1'b0;
		step();
	endtask

	task automatic rd_pair(input logic [1:0] sel, input logic [31:0] exp);
		pair_low_sel = sel;
		#1;
		check(pair_rd_data, exp);
		step();
	endtask

	task automatic t_indexed;
		logic [15:0] iv [1:3];
		logic ok;
		iv = '{16'h0003, 16'h00c8, 16'hfffb};
		for (int s = 1; s < 4; s++) begin
			load_idx(2'(s), iv[s]);
		end
		for (int sp = 0; sp < 8; sp++) begin
			for (int s = 1; s < 4; s++) begin
				ok = sp < 4;
				op(3'(sp), 2'(s), 16'h0010, 16'h0000, ok ? 16'h0010 + iv[s] : 16'h0010, ok ? iv[s] : 16'h0000, !ok);
			end
		end
	endtask

	// Source and destination take different index registers in one request
	task automatic t_split;
		load_idx(2'h1, 16'h0003);
		load_idx(2'h2, 16'h00c8);
		idx_wr_en = 1'b0;
		req_valid = 1'b1;
		src_space = iag_pkg::IAG_SPC_RW;
		dst_space = iag_pkg::IAG_SPC_D;
		src_idx_sel = 2'h1;
		dst_idx_sel = 2'h2;
		src_base = 16'h0010;
		dst_base = 16'h0000;
		step();
		check({src_ea, dst_ea}, {16'h0013, 16'h00c8});
		check({31'h0, idx_refused}, 32'h0000_0000);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (3) step();
		rd_pair(2'h1, 32'h0000_0000);
		op(iag_pkg::IAG_SPC_RW, 2'h1, 16'h0020, 16'h0030, 16'h0020, 16'h0030, 1'b0);
		op(iag_pkg::IAG_SPC_S, 2'h0, 16'h0010, 16'h1000, 16'h0010, 16'h1000, 1'b0);
		t_indexed();
		load_idx(2'h1, 16'h0005);
		op(iag_pkg::IAG_SPC_D, 2'h1, 16'h0100, 16'h0200, 16'h0105, 16'h0205, 1'b0);
		load_idx(2'h1, 16'h8000);
		op(iag_pkg::IAG_SPC_RW, 2'h1, 16'h0000, 16'h8000, 16'h8000, 16'h0000, 1'b0);
		load_idx(2'h3, 16'h7fff);
		op(iag_pkg::IAG_SPC_T, 2'h3, 16'h8001, 16'hffff, 16'h0000, 16'h7ffe, 1'b0);
		t_split();
		pair(2'h1, 32'h1234_5678, 1'b0);
		rd_pair(2'h1, 32'h1234_5678);
		pair(2'h2, 32'haaaa_bbbb, 1'b0);
		rd_pair(2'h2, 32'haaaa_bbbb);
		rd_pair(2'h1, 32'hbbbb_5678);
		pair(2'h3, 32'h0101_0202, 1'b1);
		pair(2'h0, 32'h0303_0404, 1'b1);
		rd_pair(2'h2, 32'haaaa_bbbb);
		rd_pair(2'h3, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
